// [src/plc_defs.svh]
// Purpose : constants for the configuration loader and sideband logic
// Assumes : 10 MHz system clock
// Notes   : timing counts derive from times in nanoseconds
`ifndef PLC_DEFS_SVH
`define PLC_DEFS_SVH

// ----------------------------------------------------------------
// configuration image layout
// ----------------------------------------------------------------
`define PLC_ADDR_BEGIN     8'h00
`define PLC_ADDR_LINK      8'h01
`define PLC_ADDR_PIXEL     8'h02
`define PLC_ADDR_RECOV     8'h03
`define PLC_ADDR_PLL       8'h04
`define PLC_ADDR_FINISH    8'h05
`define PLC_BEGIN_MARKER   8'hBD
`define PLC_FINISH_MARKER  8'h99
`define PLC_CFG_DEFAULT    32'h9001BCB0
`define PLC_IMG_BITS       48

// ----------------------------------------------------------------
// serial read command: start bit, read opcode, address zero
// ----------------------------------------------------------------
`define PLC_CMD_WORD       10'h300
`define PLC_CMD_BITS       6'h0A
`define PLC_LAST_PERIOD    6'h3A

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PLC_CLK_NS         100
`define PLC_START_NS       650
`define PLC_CFG_HALF_NS    800
`define PLC_WAIT_NS        50000000
`define PLC_START_CYC      ((`PLC_START_NS + `PLC_CLK_NS - 1) / `PLC_CLK_NS)
`define PLC_CFG_HALF_CYC   (`PLC_CFG_HALF_NS / `PLC_CLK_NS)
`define PLC_WAIT_CYC       (`PLC_WAIT_NS / `PLC_CLK_NS)
`define PLC_UP_FRAME       4'hF

`endif

// [src/plc_pkg.sv]
// Purpose : types for the configuration loader
// Assumes : field layout of configuration bytes one to four
// Notes   : cfg struct packs bytes four down to one, msb first
package plc_pkg;

   // ----------------------------------------------------------------
   // configuration bytes one to four
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] rsv4_hi;
      logic [3:0] rsv4_lo;
      logic       pll_rst_dis;
      logic [2:0] err_sel;
      logic       rsv3;
      logic [3:0] recovery;
      logic [1:0] up_line_sel;
      logic       rise_edge;
      logic       rsv2;
      logic [1:0] ctrl_mode;
      logic [1:0] pix_width;
      logic       wait_en;
      logic       full_rate;
      logic       rsv1;
      logic       up_embedded_n;
      logic       up_dedicated_n;
      logic [2:0] preemph_dly;
   } plc_cfg_s;

   // ----------------------------------------------------------------
   // one captured pixel
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [23:0] word;
      logic [2:0]  sync;
   } plc_pix_s;

   typedef enum logic [2:0] {
      ST_START = 3'b000,
      ST_XFER  = 3'b001,
      ST_CHECK = 3'b010,
      ST_WAIT  = 3'b011,
      ST_RUN   = 3'b100
   } plc_state_e;

endpackage

// [src/plc_loader.sv]
// Purpose : configuration loader with pixel capture and sideband paths
// Assumes : serial memory answers a read command with all six bytes
// Notes   : config data, pixel, downstream sideband and pll lock pins pass two flip-flops before use
//
// Behaviour
// - after reset, read configuration from serial memory before normal operation
// - failed load ignores received bytes and applies every default value
// - byte zero must be 10111101 for the image to count as valid
// - byte five must be 10011001 for the image to count as valid
// - byte one bits 2:0 set pre-emphasis delay, default 000
// - byte one bits 3 and 4 enable dedicated and embedded upstream when 0; upstream runs here only when exactly one of them is 0
// - byte one bit 6 selects half rate (0) or full rate (1)
// - byte one bit 7 set waits 50 ms after configuration
// - byte two bits 1:0 pick pixel width 10, 12, 18 or 24 bits
// - byte two bits 3:2 send control never, on even pixels or always
// - byte two bit 5 samples pixels on rising (1) or falling (0) edge
// - full rate: bits 7:6 give 62.5, 41.67 or 31.25 MHz upstream clock
// - half rate: bits 7:6 of 00 give 62.5, 10 give 31.25 MHz
// - half rate: bits 7:6 of 11 give 20.83 MHz
// - byte three bits 3:0 set upstream data recovery, default 0001
// - byte three bits 7:5 select what the error pin reports
// - error code 000 reports sync loss, 001 sync restart, rest reserved
// - byte four bit 0 clear lets lost pll lock reset the device
// - upstream sideband data changes in step with its own clock output
// - upstream sideband rate stays below the limit of the line clock
// - half rate: sample downstream sideband pins at the slow rate
// - full rate: sample downstream sideband pins at twice that rate
// - error output is active high; reset clears the device
`timescale 1ns/1ps
`include "plc_defs.svh"

module plc_loader
   import plc_pkg::*;
#(
   parameter int WAIT_CYC = `PLC_WAIT_CYC
) (
   input  wire logic        sys_clk_i,
   input  wire logic        nrst_i,
   output logic             cfg_clk_o,
   input  wire logic        cfg_data_i,
   output logic             cfg_data_o,
   output logic             cfg_data_oe_n_o,
   output plc_cfg_s         cfg_o,
   output logic             cfg_ok_o,
   output logic             run_o,
   input  wire logic        pixel_clock_in_i,
   input  wire logic [23:0] pixel_word_in_i,
   input  wire logic [2:0]  pixel_sync_in_i,
   output logic             pix_in_ready_o,
   output plc_pix_s         pix_o,
   output logic             pix_valid_o,
   input  wire logic        pix_ready_i,
   input  wire logic [1:0]  down_side_in_i,
   output logic [1:0]       down_pkt_o,
   output logic             down_pkt_stb_o,
   input  wire logic [1:0]  up_rx_data_i,
   output logic [1:0]       up_side_out_o,
   output logic             up_side_clock_o,
   input  wire logic        up_sync_lost_i,
   input  wire logic        up_sync_restarted_i,
   output logic             up_err_o,
   input  wire logic        pll_lock_i,
   output logic             pll_rst_o
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // half period of the upstream sideband clock in system cycles
   function automatic logic [2:0] up_half(input logic full, input logic [1:0] sel);
      logic [2:0] h;
      h = 3'h4;
      case (sel)
         2'b00:   h = 3'h2;
         2'b01:   h = full ? 3'h3 : 3'h4;
         2'b10:   h = 3'h4;
         default: h = 3'h6;
      endcase
      return h;
   endfunction

   // mask pixel word to the configured width
   function automatic logic [23:0] width_mask(input logic [1:0] w);
      logic [23:0] m;
      m = 24'hFFFFFF;
      case (w)
         2'b00:   m = 24'h0003FF;
         2'b01:   m = 24'h000FFF;
         2'b10:   m = 24'h03FFFF;
         default: m = 24'hFFFFFF;
      endcase
      return m;
   endfunction

   // command bit sent in bit period b, msb first, zero after the command
   function automatic logic cmd_bit_at(input logic [5:0] b);
      logic [9:0] w;
      w = `PLC_CMD_WORD;
      return (b < `PLC_CMD_BITS) ? w[4'd9 - b[3:0]] : 1'b0;
   endfunction

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   // cfg data, pixel clock, pixel word, pixel sync, downstream sideband pins, pll lock
   localparam int PIN_W = 32;

   logic [PIN_W-1:0] meta_q;
   logic [PIN_W-1:0] sync_q;

   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= {cfg_data_i, pixel_clock_in_i, pixel_word_in_i,
                    pixel_sync_in_i, down_side_in_i, pll_lock_i};
         sync_q <= meta_q;
      end
   end

   wire        cfg_din_s  = sync_q[31];
   wire        pclk_s     = sync_q[30];
   wire [23:0] pword_s    = sync_q[29:6];
   wire [2:0]  psync_s    = sync_q[5:3];
   wire [1:0]  down_s     = sync_q[2:1];
   wire        pll_lock_s = sync_q[0];

   // ----------------------------------------------------------------
   // configuration sequencer
   // ----------------------------------------------------------------
   plc_state_e state_q;
   plc_state_e state_d;
   logic [31:0] cyc_q;
   logic [3:0]  ph_q;
   logic [5:0]  bit_q;
   logic [47:0] shift_q;
   plc_cfg_s    cfg_q;
   logic        ok_q;
   logic        pll_prev_q;

   wire ph_end      = (ph_q == 4'(2 * `PLC_CFG_HALF_CYC - 1));
   wire sample_pt   = (ph_q == 4'(`PLC_CFG_HALF_CYC - 1));
   wire in_cmd      = (bit_q < `PLC_CMD_BITS);
   wire in_data     = (bit_q > `PLC_CMD_BITS);
   wire xfer_done   = (state_q == ST_XFER) && ph_end && (bit_q == `PLC_LAST_PERIOD);
   wire begin_ok    = (shift_q[47:40] == `PLC_BEGIN_MARKER);
   wire finish_ok   = (shift_q[7:0] == `PLC_FINISH_MARKER);
   wire img_ok      = begin_ok && finish_ok;

   // image bytes one to four rearranged into field order, byte four on top
   plc_cfg_s img_cfg;
   assign img_cfg = {shift_q[15:8], shift_q[23:16],
                     shift_q[31:24], shift_q[39:32]};

   wire start_done  = (cyc_q == 32'(`PLC_START_CYC - 1));
   wire wait_done   = (cyc_q >= 32'(WAIT_CYC - 1));
   wire pll_lost    = pll_prev_q && !pll_lock_s;
   wire pll_restart = (state_q == ST_RUN) && pll_lost && !cfg_q.pll_rst_dis;
   wire cmd_bit     = cmd_bit_at(bit_q);

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_START: if (start_done) state_d = ST_XFER;
         ST_XFER:  if (xfer_done) state_d = ST_CHECK;
         ST_CHECK: begin
            if (img_ok ? img_cfg.wait_en : 1'b1) begin
               state_d = ST_WAIT;
            end else begin
               state_d = ST_RUN;
            end
         end
         ST_WAIT:  if (wait_done) state_d = ST_RUN;
         ST_RUN:   if (pll_restart) state_d = ST_START;
         default:  state_d = ST_START;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         state_q <= ST_START;
         cyc_q   <= '0;
         ph_q    <= '0;
         bit_q   <= '0;
      end else begin
         state_q <= state_d;
         cyc_q   <= (state_d != state_q) ? 32'h0 : cyc_q + 32'h1;
         ph_q    <= (state_q == ST_XFER && !ph_end) ? ph_q + 4'h1 : 4'h0;
         if (state_q != ST_XFER) begin
            bit_q <= '0;
         end else if (ph_end) begin
            bit_q <= bit_q + 6'h1;
         end
      end
   end

   // serial pins and image capture
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         cfg_clk_o       <= 1'b0;
         cfg_data_o      <= 1'b0;
         cfg_data_oe_n_o <= 1'b1;
         shift_q         <= '0;
         cfg_q           <= `PLC_CFG_DEFAULT;
         ok_q            <= 1'b0;
      end else begin
         cfg_clk_o       <= (state_q == ST_XFER) && (ph_q >= 4'(`PLC_CFG_HALF_CYC - 1))
                            && !ph_end;
         cfg_data_o      <= (state_q == ST_XFER) && in_cmd && cmd_bit;
         cfg_data_oe_n_o <= !((state_q == ST_XFER) && in_cmd);
         if (state_q == ST_XFER && sample_pt && in_data) begin
            shift_q <= {shift_q[46:0], cfg_din_s};
         end
         if (state_q == ST_START) begin
            ok_q <= 1'b0;
         end else if (state_q == ST_CHECK) begin
            ok_q  <= img_ok;
            cfg_q <= img_ok ? img_cfg : plc_cfg_s'(`PLC_CFG_DEFAULT);
         end
      end
   end

   // ----------------------------------------------------------------
   // applied configuration and status outputs
   // ----------------------------------------------------------------
   wire running = (state_q == ST_RUN);
   // upstream runs only with exactly one of its two paths enabled
   wire up_on   = cfg_q.up_dedicated_n ^ cfg_q.up_embedded_n;

   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         cfg_o      <= `PLC_CFG_DEFAULT;
         cfg_ok_o   <= 1'b0;
         run_o      <= 1'b0;
         pll_prev_q <= 1'b0;
         pll_rst_o  <= 1'b0;
         up_err_o   <= 1'b0;
      end else begin
         cfg_o      <= cfg_q;
         cfg_ok_o   <= ok_q;
         run_o      <= running;
         pll_prev_q <= pll_lock_s;
         pll_rst_o  <= pll_restart;
         case (cfg_q.err_sel)
            3'b000:  up_err_o <= running && up_on && up_sync_lost_i;
            3'b001:  up_err_o <= running && up_on && up_sync_restarted_i;
            default: up_err_o <= 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // pixel capture and two-entry buffer
   // ----------------------------------------------------------------
   logic     pclk_prev_q;
   logic     even_q;
   logic [1:0] cnt_q;
   plc_pix_s   e1_q;

   wire pclk_rise = pclk_s && !pclk_prev_q;
   wire pclk_fall = !pclk_s && pclk_prev_q;
   wire pix_edge  = running && (cfg_q.rise_edge ? pclk_rise : pclk_fall);
   wire send_ctrl = (cfg_q.ctrl_mode == 2'b11) ||
                    (cfg_q.ctrl_mode == 2'b10 && !even_q);
   wire push      = pix_edge && (cnt_q != 2'd2);
   wire pop       = pix_valid_o && pix_ready_i;
   wire [1:0] cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

   wire [23:0] new_word = pword_s & width_mask(cfg_q.pix_width);
   wire [2:0]  new_sync = send_ctrl ? psync_s : 3'b000;
   plc_pix_s   new_pix;
   assign new_pix = {new_word, new_sync};

   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         pclk_prev_q    <= 1'b0;
         even_q         <= 1'b0;
         cnt_q          <= 2'd0;
         pix_o          <= '0;
         e1_q           <= '0;
         pix_valid_o    <= 1'b0;
         pix_in_ready_o <= 1'b0;
      end else begin
         pclk_prev_q    <= pclk_s;
         cnt_q          <= cnt_d;
         pix_valid_o    <= (cnt_d != 2'd0);
         pix_in_ready_o <= (cnt_d != 2'd2);
         if (!running) begin
            even_q <= 1'b0;
         end else if (push) begin
            even_q <= !even_q;
         end
         if (pop) begin
            if (cnt_q == 2'd2) begin
               pix_o <= e1_q;
               if (push) e1_q <= new_pix;
            end else if (push) begin
               pix_o <= new_pix;
            end
         end else if (push) begin
            if (cnt_q == 2'd0) begin
               pix_o <= new_pix;
            end else begin
               e1_q <= new_pix;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // downstream sideband sampling
   // ----------------------------------------------------------------
   logic div2_q;

   wire down_take = running && (cfg_q.full_rate || div2_q);

   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         div2_q         <= 1'b0;
         down_pkt_o     <= 2'b00;
         down_pkt_stb_o <= 1'b0;
      end else begin
         div2_q         <= !div2_q;
         down_pkt_stb_o <= down_take;
         if (down_take) begin
            down_pkt_o <= down_s;
         end
      end
   end

   // ----------------------------------------------------------------
   // upstream sideband clock and data
   // ----------------------------------------------------------------
   logic [2:0] up_cnt_q;
   logic [3:0] up_frame_q;

   wire [2:0] up_h   = up_half(cfg_q.full_rate, cfg_q.up_line_sel);
   wire       up_tgl = (up_cnt_q == up_h - 3'h1);
   wire       up_gap = (up_frame_q == `PLC_UP_FRAME);

   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         up_cnt_q        <= 3'h0;
         up_frame_q      <= 4'h0;
         up_side_clock_o <= 1'b0;
         up_side_out_o   <= 2'b00;
      end else if (!running || !up_on) begin
         up_cnt_q        <= 3'h0;
         up_frame_q      <= 4'h0;
         up_side_clock_o <= 1'b0;
         up_side_out_o   <= 2'b00;
      end else begin
         up_cnt_q <= up_tgl ? 3'h0 : up_cnt_q + 3'h1;
         if (up_tgl) begin
            if (up_side_clock_o) begin
               up_side_clock_o <= 1'b0;
               up_frame_q      <= up_frame_q + 4'h1;
               up_side_out_o   <= up_rx_data_i;
            end else begin
               up_side_clock_o <= !up_gap;
               if (up_gap) up_frame_q <= 4'h0;
            end
         end
      end
   end

endmodule

// [sim/plc_loader_properties.sv]
// Purpose : port assertions for the configuration loader
// Assumes : one clock domain, synchronous active-low reset
// Notes   : attached to every plc_loader by bind
`timescale 1ns/1ps
`include "plc_defs.svh"
module plc_loader_checker
   import plc_pkg::*;
#(
   parameter int WAIT_CYC = 20
) (
   input wire logic       sys_clk_i,
   input wire logic       nrst_i,
   input wire logic       cfg_clk_o,
   input wire logic       cfg_data_oe_n_o,
   input wire plc_cfg_s   cfg_o,
   input wire logic       cfg_ok_o,
   input wire logic       run_o,
   input wire plc_pix_s   pix_o,
   input wire logic       pix_valid_o,
   input wire logic       pix_ready_i,
   input wire logic       down_pkt_stb_o,
   input wire logic [1:0] up_side_out_o,
   input wire logic       up_side_clock_o,
   input wire logic       up_sync_lost_i,
   input wire logic       up_err_o,
   input wire logic       pll_rst_o
);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);

   rst_state_a: assert property ($rose(nrst_i) |-> cfg_data_oe_n_o && !run_o
      && cfg_o == `PLC_CFG_DEFAULT) else $error("state after reset wrong");
   cfg_clk_high_a: assert property ($rose(cfg_clk_o) |=> cfg_clk_o [*7] ##1 !cfg_clk_o)
      else $error("config clock high time wrong");
   load_first_a: assert property (!cfg_data_oe_n_o |-> !run_o)
      else $error("running while loading");
   default_cfg_a: assert property (run_o && !cfg_ok_o |-> cfg_o == `PLC_CFG_DEFAULT)
      else $error("defaults not applied");
   half_strobe_a: assert property (down_pkt_stb_o && !cfg_o.full_rate |=> !down_pkt_stb_o)
      else $error("half rate strobe too dense");
   err_lost_a: assert property ($stable(cfg_o) && cfg_o.err_sel == 3'h0
      |-> up_err_o == $past(up_sync_lost_i)) else $error("error pin misses sync loss");
   err_rsv_a: assert property ($stable(cfg_o) && cfg_o.err_sel[2:1] != 2'h0 |-> !up_err_o)
      else $error("reserved error code drives pin");
   up_data_edge_a: assert property (run_o && $past(run_o) && $changed(up_side_out_o)
      |-> $fell(up_side_clock_o)) else $error("sideband data off clock edge");
   pll_pulse_a: assert property (pll_rst_o |-> !cfg_o.pll_rst_dis ##1 !pll_rst_o && !run_o)
      else $error("pll reset pulse wrong");
   pix_hold_a: assert property (pix_valid_o && !pix_ready_i |=> pix_valid_o && $stable(pix_o))
      else $error("pixel head lost under stall");
endmodule

bind plc_loader plc_loader_checker #(.WAIT_CYC(WAIT_CYC)) plc_loader_checker_inst (
   .sys_clk_i, .nrst_i, .cfg_clk_o, .cfg_data_oe_n_o, .cfg_o, .cfg_ok_o, .run_o, .pix_o,
   .pix_valid_o, .pix_ready_i, .down_pkt_stb_o, .up_side_out_o, .up_side_clock_o,
   .up_sync_lost_i, .up_err_o, .pll_rst_o);

// [sim/plc_cfg_rom.sv]
// Purpose : serial memory serving a six byte image
// Assumes : read command ends at the tenth clock rise
// Notes   : line is released to the inverse of its last value
`timescale 1ns/1ps
module plc_cfg_rom (
   input  wire logic        cfg_clk_i,
   input  wire logic        take_n_i,
   input  wire logic        line_i,
   input  wire logic [47:0] image_i,
   output logic             data_o,
   output logic [9:0]       cmd_o
);
   int rise = 0;
   initial data_o = 1'b0;
   initial cmd_o = '0;
   // restart count whenever the loader sends a new command
   always @(negedge take_n_i) rise = 0;
   // serve bytes zero to five msb first after each rise
   always @(posedge cfg_clk_i) begin
      if (rise < 10) cmd_o <= {cmd_o[8:0], line_i};
      if (rise >= 10 && rise < 58) begin
         data_o <= image_i[57 - rise];
      end else begin
         data_o <= ~data_o;
      end
      rise <= rise + 1;
   end
endmodule

// [sim/plc_loader_test.sv]
// Purpose : self-checking bench for the configuration loader
// Assumes : serial memory model on the configuration pins
// Notes   : wait count shortened to WAIT cycles
`timescale 1ns/1ps
`include "plc_defs.svh"
module plc_loader_test;
   import plc_pkg::*;
   localparam int WAIT = 200;
   logic        sys_clk_i = 0, nrst_i = 0, pixel_clock_in_i = 0, pix_ready_i = 0;
   logic        pll_lock_i = 1, up_sync_lost_i = 0, up_sync_restarted_i = 0;
   logic [23:0] pixel_word_in_i = '0;
   logic [2:0]  pixel_sync_in_i = '0;
   logic [1:0]  down_side_in_i = '0, up_rx_data_i = '0, down_pkt_o, up_side_out_o;
   logic        cfg_clk_o, cfg_data_o, cfg_data_oe_n_o, cfg_ok_o, run_o, pix_in_ready_o;
   logic        pix_valid_o, down_pkt_stb_o, up_side_clock_o, up_err_o, pll_rst_o;
   logic        rom_q, cfg_wire;
   logic [9:0]  rom_cmd;
   logic [47:0] img = '0;
   plc_cfg_s    cfg_o;
   plc_pix_s    pix_o;
   int          err_total = 0, checked = 0;
   int          hp_t [5] = '{2, 3, 4, 6, 2};

   always #50 sys_clk_i = ~sys_clk_i;
   assign cfg_wire = cfg_data_oe_n_o ? rom_q : cfg_data_o;

   plc_loader #(.WAIT_CYC(WAIT)) plc_loader_inst (
      .sys_clk_i, .nrst_i, .cfg_clk_o, .cfg_data_i(cfg_wire), .cfg_data_o, .cfg_data_oe_n_o,
      .cfg_o, .cfg_ok_o, .run_o, .pixel_clock_in_i, .pixel_word_in_i, .pixel_sync_in_i,
      .pix_in_ready_o, .pix_o, .pix_valid_o, .pix_ready_i, .down_side_in_i, .down_pkt_o,
      .down_pkt_stb_o, .up_rx_data_i, .up_side_out_o, .up_side_clock_o, .up_sync_lost_i,
      .up_sync_restarted_i, .up_err_o, .pll_lock_i, .pll_rst_o);
   plc_cfg_rom plc_cfg_rom_inst (
      .cfg_clk_i(cfg_clk_o), .take_n_i(cfg_data_oe_n_o), .line_i(cfg_wire), .image_i(img),
      .data_o(rom_q), .cmd_o(rom_cmd));

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic summarize;
      $display("mismatches %0d comparisons %0d", err_total, checked);
      if (err_total == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // reset, let the loader fetch the image, judge the applied fields
   task automatic t_load(input logic [47:0] im, input logic ok);
      int          n;
      logic [31:0] exp;
      img = im;
      nrst_i = 0;
      repeat (4) @(negedge sys_clk_i);
      chk("rst_oe_n", 1, cfg_data_oe_n_o);
      chk("rst_cfg", `PLC_CFG_DEFAULT, cfg_o);
      nrst_i = 1;
      n = 0;
      while (run_o !== 1'b1 && n < 3000) begin
         @(negedge sys_clk_i);
         n++;
      end
      exp = ok ? {im[15:8], im[23:16], im[31:24], im[39:32]} : `PLC_CFG_DEFAULT;
      chk("run", 1, run_o);
      chk("cmd", `PLC_CMD_WORD, rom_cmd);
      chk("cfg_ok", ok, cfg_ok_o);
      chk("cfg", exp, cfg_o);
      chk("wait", exp[7], n > 1050);
   endtask

   // sideband rates, upstream clock and error pin mapping
   task automatic t_side(input logic full, input logic [2:0] err, input int hp);
      int   c, e, mn;
      logic last;
      down_side_in_i = 2'h2;
      up_rx_data_i = 2'h1;
      c = 0;
      repeat (20) begin
         @(negedge sys_clk_i);
         c += down_pkt_stb_o;
      end
      chk("stb_count", full ? 20 : 10, c);
      chk("down_pkt", 2'h2, down_pkt_o);
      last = up_side_clock_o;
      c = 0;
      e = 0;
      mn = 99;
      repeat (300) begin
         @(negedge sys_clk_i);
         c++;
         if (up_side_clock_o !== last) begin
            if (e > 0 && c < mn) mn = c;
            e++;
            c = 0;
            last = up_side_clock_o;
         end
      end
      chk("up_half", hp, mn);
      chk("up_data", 2'h1, up_side_out_o);
      up_sync_lost_i = 1;
      repeat (3) @(negedge sys_clk_i);
      chk("err_lost", err == 3'h0, up_err_o);
      up_sync_lost_i = 0;
      up_sync_restarted_i = 1;
      repeat (3) @(negedge sys_clk_i);
      chk("err_restart", err == 3'h1, up_err_o);
      up_sync_restarted_i = 0;
   endtask

   // three pixels into a stalled two-entry buffer, then drain
   task automatic t_pixel(input logic [23:0] msk, input logic [2:0] sync2);
      for (int i = 1; i < 4; i++) begin
         pixel_word_in_i = 24'h555400 | 24'(i);
         pixel_sync_in_i = 3'h5;
         repeat (2) @(negedge sys_clk_i);
         pixel_clock_in_i = 1;
         repeat (4) @(negedge sys_clk_i);
         pixel_clock_in_i = 0;
         repeat (2) @(negedge sys_clk_i);
      end
      repeat (4) @(negedge sys_clk_i);
      chk("in_ready_full", 0, pix_in_ready_o);
      chk("head1", {24'h555401 & msk, 3'h5}, pix_o);
      pix_ready_i = 1;
      @(negedge sys_clk_i);
      chk("head2", {24'h555402 & msk, sync2}, pix_o);
      @(negedge sys_clk_i);
      chk("drained", 0, pix_valid_o);
      pix_ready_i = 0;
      chk("in_ready_free", 1, pix_in_ready_o);
   endtask

   // lock loss in run: pulse and reload unless supervision is off
   task automatic t_pll(input logic dis);
      int   p;
      logic o;
      p = 0;
      o = 0;
      pll_lock_i = 0;
      repeat (20) begin
         @(negedge sys_clk_i);
         p += pll_rst_o;
         o |= !cfg_data_oe_n_o;
      end
      chk("pll_pulse", !dis, p);
      chk("reload", !dis, o);
      pll_lock_i = 1;
   endtask

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      logic       full;
      logic [1:0] sel;
      logic [2:0] err;
      logic [3:0] rec;
      t_load(48'hBC727C019099, 0);
      t_load(48'hBD727C019098, 0);
      for (int i = 0; i < 5; i++) begin
         full = (i < 3);
         sel = (i == 4) ? 2'h0 : 2'(i);
         err = 3'(i % 3);
         rec = (hp_t[i] == 2 || hp_t[i] == 6) ? 4'h3 : 4'h1;
         t_load({8'hBD, 1'b0, full, 6'h32, sel, 6'h3C, err, 1'b0, rec, 8'h90, 8'h99}, 1);
         t_side(full, err, hp_t[i]);
      end
      t_pixel(24'h0003FF, 3'h5);
      t_pll(0);
      t_load(48'hBDF27C019199, 1);
      t_pll(1);
      t_load(48'hBDB099019099, 1);
      t_pixel(24'h000FFF, 3'h0);
      summarize;
   end

   initial begin
      repeat (40000) @(posedge sys_clk_i);
      err_total++;
      summarize;
   end
endmodule
